// ### tcrs_defs.svh
/*
 Constants of the Type-C port role and strap block: addresses, mode codes and timing counts.
 Assumes a 20 MHz core clock; included by tcrs_port_ctrl and the checker.
*/
`ifndef TCRS_DEFS_SVH
`define TCRS_DEFS_SVH
// Contract
// - Address strap tied high or low selects I2C.
// - Address strap low answers at 0x47.
// - Role strap floating gives dual-role port.
// - Role strap high gives source role.
// - Role strap low gives sink role.
// - Role override applies only while unattached.
// - Enable pin high holds shutdown until low.
// - Change output pulls low on register change.
// - Dual-role attached as source pulls host flag.
// - Host flag is open-drain, pull low only.
// - Dual-role alternates advertised role until attached.
// - After reset sample role strap while unattached.
`define TCRS_ADDR_STRAP_LO 7'h47
`define TCRS_ADDR_STRAP_HI 7'h67
`define TCRS_ADDR_NONE 7'h00
`define TCRS_MODE_STRAP 2'h0
`define TCRS_MODE_SINK 2'h1
`define TCRS_MODE_SOURCE 2'h2
`define TCRS_MODE_DRP 2'h3
`define TCRS_SETTLE_CYC 2'h3
`define TCRS_CLK_KHZ 20000
`define TCRS_DRP_HALF_MS 35
`define TCRS_CORE_SYNC_W 9
`endif

// ### tcrs_pkg.sv
/*
 Types of the Type-C port role and strap block.
 Assumes tcrs_defs.svh is on the include path.
*/
package tcrs_pkg;
   typedef enum logic [1:0] {
      ROLE_SINK,
      ROLE_SOURCE,
      ROLE_DRP
   } tcrs_role_t;
   typedef enum logic [1:0] {
      PH_SETTLE,
      PH_UNATT,
      PH_ATT
   } tcrs_phase_t;
   typedef struct packed {
      logic addr_hi;
      logic addr_lo;
      logic port_hi;
      logic port_lo;
   } tcrs_strap_t;
endpackage

// ### tcrs_sync.sv
/*
 Two flip-flop synchroniser, one chain per bit, with a clock enable.
 Assumes each bit is a level that stays put for at least two destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tcrs_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   // Data.
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_ff[i] <= 1'b0;
               q[i] <= 1'b0;
            end else if (en) begin
               meta_ff[i] <= d[i];
               q[i] <= meta_ff[i];
            end
         end
      end
   endgenerate
endmodule // tcrs_sync
`default_nettype wire

// ### tcrs_port_ctrl.sv
/*
 Strap decode, port role selection, dual-role toggling, shutdown and the two open-drain
 status outputs of a Type-C port controller.
 Assumes straps, enable and bus power arrive asynchronously, the CC detector drives the
 attach inputs on clk, and the register side runs on link_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcrs_defs.svh"
module tcrs_port_ctrl #(
   parameter int unsigned DRP_HALF_CYC = `TCRS_DRP_HALF_MS * `TCRS_CLK_KHZ
) (
   // Core clock, reset and enable.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Strap and sense pins.
   input wire tcrs_pkg::tcrs_strap_t strap_pins,
   input wire logic enable_n,
   input wire logic bus_power_sense,
   // Attach detection from the CC logic.
   input wire logic attach_src_det,
   input wire logic attach_snk_det,
   // Register side on the link clock.
   input wire logic link_clk,
   input wire logic reg_change,
   input wire logic notify_clear,
   input wire logic role_ovr_wr,
   input wire logic [1:0] role_ovr_val,
   output logic notify_status_link,
   // Status.
   output logic i2c_mode,
   output logic [6:0] i2c_addr,
   output tcrs_pkg::tcrs_role_t port_role,
   output logic attached,
   output logic adv_source,
   output logic shutdown,
   // Open-drain change notification.
   input wire logic change_notify_n_i,
   output logic change_notify_n_o,
   output logic change_notify_n_oe,
   // Open-drain host role flag.
   input wire logic host_role_flag_n_i,
   output logic host_role_flag_n_o,
   output logic host_role_flag_n_oe
);
   logic reg_tgl_ff;
   logic clr_tgl_ff;
   logic ovr_tgl_ff;
   logic [1:0] ovr_val_ff;
   logic [`TCRS_CORE_SYNC_W-1:0] syn;
   logic [2:0] tgl_d_ff;
   tcrs_pkg::tcrs_strap_t straps;
   logic en_n_s;
   logic bus_pwr_s;
   logic ev_reg;
   logic ev_clr;
   logic ev_ovr;
   tcrs_pkg::tcrs_phase_t phase_ff;
   tcrs_pkg::tcrs_phase_t nxt_phase;
   logic [1:0] settle_ff;
   tcrs_pkg::tcrs_role_t strap_role_ff;
   tcrs_pkg::tcrs_role_t nxt_role;
   logic [1:0] mode_sel_ff;
   logic [31:0] drp_cnt_ff;
   logic attach_now;
   logic pend_ff;
   logic set_pend;

   // Register-side events become toggles; the override word is held until the next write.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_tgl_ff <= 1'b0;
         clr_tgl_ff <= 1'b0;
         ovr_tgl_ff <= 1'b0;
         ovr_val_ff <= `TCRS_MODE_STRAP;
      end else begin
         reg_tgl_ff <= reg_tgl_ff ^ reg_change;
         clr_tgl_ff <= clr_tgl_ff ^ notify_clear;
         if (role_ovr_wr) begin
            ovr_tgl_ff <= ~ovr_tgl_ff;
            ovr_val_ff <= role_ovr_val;
         end
      end
   end

   tcrs_sync #(.WIDTH(1)) u_sync_link (
      .clk(link_clk),
      .rst_b(rst_b),
      .en(1'b1),
      .d(pend_ff),
      .q(notify_status_link)
   );

   tcrs_sync #(.WIDTH(`TCRS_CORE_SYNC_W)) u_sync_core (
      .clk(clk),
      .rst_b(rst_b),
      .en(clk_en),
      .d({strap_pins, enable_n, bus_power_sense, reg_tgl_ff, clr_tgl_ff, ovr_tgl_ff}),
      .q(syn)
   );

   assign straps = syn[8:5];
   assign en_n_s = syn[4];
   assign bus_pwr_s = syn[3];
   assign ev_reg = syn[2] ^ tgl_d_ff[2];
   assign ev_clr = syn[1] ^ tgl_d_ff[1];
   assign ev_ovr = syn[0] ^ tgl_d_ff[0];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_d_ff <= 3'h0;
      end else if (clk_en) begin
         tgl_d_ff <= syn[2:0];
      end
   end

   // A sink attach only counts once bus power is seen.
   assign attach_now = attach_src_det | (attach_snk_det & bus_pwr_s);

   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         tcrs_pkg::PH_SETTLE: begin
            if (settle_ff == `TCRS_SETTLE_CYC) begin
               nxt_phase = tcrs_pkg::PH_UNATT;
            end
         end
         tcrs_pkg::PH_UNATT: begin
            if (attach_now) begin
               nxt_phase = tcrs_pkg::PH_ATT;
            end
         end
         tcrs_pkg::PH_ATT: begin
            if (!attach_now) begin
               nxt_phase = tcrs_pkg::PH_UNATT;
            end
         end
         default: nxt_phase = tcrs_pkg::PH_SETTLE;
      endcase
      if (en_n_s) begin
         nxt_phase = tcrs_pkg::PH_SETTLE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_ff <= tcrs_pkg::PH_SETTLE;
         settle_ff <= 2'h0;
      end else if (clk_en) begin
         phase_ff <= nxt_phase;
         if (phase_ff == tcrs_pkg::PH_SETTLE && !en_n_s) begin
            settle_ff <= settle_ff + 2'h1;
         end else begin
            settle_ff <= 2'h0;
         end
      end
   end

   // Straps are caught once the synchronisers have settled after reset or shutdown.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_role_ff <= tcrs_pkg::ROLE_SINK;
         i2c_mode <= 1'b0;
         i2c_addr <= `TCRS_ADDR_NONE;
      end else if (clk_en && phase_ff == tcrs_pkg::PH_SETTLE && settle_ff == `TCRS_SETTLE_CYC) begin
         if (straps.port_hi) begin
            strap_role_ff <= tcrs_pkg::ROLE_SOURCE;
         end else if (straps.port_lo) begin
            strap_role_ff <= tcrs_pkg::ROLE_SINK;
         end else begin
            strap_role_ff <= tcrs_pkg::ROLE_DRP;
         end
         i2c_mode <= straps.addr_hi ^ straps.addr_lo;
         if (straps.addr_lo && !straps.addr_hi) begin
            i2c_addr <= `TCRS_ADDR_STRAP_LO;
         end else if (straps.addr_hi && !straps.addr_lo) begin
            i2c_addr <= `TCRS_ADDR_STRAP_HI;
         end else begin
            i2c_addr <= `TCRS_ADDR_NONE;
         end
      end
   end

   always_comb begin
      case (mode_sel_ff)
         `TCRS_MODE_SINK: nxt_role = tcrs_pkg::ROLE_SINK;
         `TCRS_MODE_SOURCE: nxt_role = tcrs_pkg::ROLE_SOURCE;
         `TCRS_MODE_DRP: nxt_role = tcrs_pkg::ROLE_DRP;
         default: nxt_role = strap_role_ff;
      endcase
   end

   // The override is stored at once but only reaches the role while unattached.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_sel_ff <= `TCRS_MODE_STRAP;
         port_role <= tcrs_pkg::ROLE_SINK;
      end else if (clk_en) begin
         if (ev_ovr) begin
            mode_sel_ff <= ovr_val_ff;
         end
         if (phase_ff == tcrs_pkg::PH_UNATT) begin
            port_role <= nxt_role;
         end
      end
   end

   // Dual-role toggles its advertisement every half period until an attach holds it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drp_cnt_ff <= 32'h0;
         adv_source <= 1'b0;
      end else if (clk_en) begin
         if (phase_ff != tcrs_pkg::PH_UNATT || port_role != tcrs_pkg::ROLE_DRP) begin
            drp_cnt_ff <= 32'h0;
         end else if (drp_cnt_ff == DRP_HALF_CYC - 32'h1) begin
            drp_cnt_ff <= 32'h0;
         end else begin
            drp_cnt_ff <= drp_cnt_ff + 32'h1;
         end
         if (phase_ff == tcrs_pkg::PH_SETTLE) begin
            adv_source <= 1'b0;
         end else if (port_role == tcrs_pkg::ROLE_SOURCE) begin
            adv_source <= 1'b1;
         end else if (port_role == tcrs_pkg::ROLE_SINK) begin
            adv_source <= 1'b0;
         end else if (phase_ff == tcrs_pkg::PH_ATT) begin
            adv_source <= attach_src_det;
         end else if (drp_cnt_ff == DRP_HALF_CYC - 32'h1) begin
            adv_source <= ~adv_source;
         end
      end
   end

   // A register change, a phase change out of UNATT or ATT, or a role change while unattached raises the notification; a set beats a clear.
   assign set_pend = ev_reg || (nxt_phase != phase_ff && phase_ff != tcrs_pkg::PH_SETTLE)
      || (phase_ff == tcrs_pkg::PH_UNATT && nxt_role != port_role);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_ff <= 1'b0;
         change_notify_n_o <= 1'b0;
         change_notify_n_oe <= 1'b0;
      end else if (clk_en) begin
         pend_ff <= set_pend | (pend_ff & ~ev_clr);
         change_notify_n_o <= 1'b0;
         change_notify_n_oe <= set_pend | (pend_ff & ~ev_clr);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         host_role_flag_n_o <= 1'b0;
         host_role_flag_n_oe <= 1'b0;
         attached <= 1'b0;
         shutdown <= 1'b0;
      end else if (clk_en) begin
         host_role_flag_n_o <= 1'b0;
         host_role_flag_n_oe <= port_role == tcrs_pkg::ROLE_DRP
            && phase_ff == tcrs_pkg::PH_ATT && attach_src_det && !en_n_s;
         attached <= phase_ff == tcrs_pkg::PH_ATT;
         shutdown <= en_n_s;
      end
   end
endmodule // tcrs_port_ctrl
`default_nettype wire

// ### tcrs_port_ctrl_properties.sv
/* Concurrent checks on the ports of tcrs_port_ctrl.
 Assumes it is bound into the design and sees its core clock and reset. */
`timescale 1ns/1ps
`default_nettype none
`include "tcrs_defs.svh"
module tcrs_port_ctrl_properties #(
   parameter int unsigned DRP_HALF_CYC = `TCRS_DRP_HALF_MS * `TCRS_CLK_KHZ
) (
   // Core side.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic enable_n,
   input wire logic attach_src_det,
   // Status.
   input wire logic i2c_mode,
   input wire logic [6:0] i2c_addr,
   input wire tcrs_pkg::tcrs_role_t port_role,
   input wire logic attached,
   input wire logic adv_source,
   input wire logic shutdown,
   // Open-drain pins.
   input wire logic change_notify_n_o,
   input wire logic host_role_flag_n_o,
   input wire logic host_role_flag_n_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [31:0] hold_ff;
   logic last_ff;
   logic [2:0] wake_ff;
   // Counts enabled cycles since the advertised role last moved while toggling is due.
   // The strap settle time after leaving shutdown does not count towards the limit.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_ff <= 32'h0;
         last_ff <= 1'b0;
         wake_ff <= 3'h0;
      end else begin
         last_ff <= adv_source;
         if (shutdown) begin
            wake_ff <= 3'h4;
         end else if (clk_en && wake_ff != 3'h0) begin
            wake_ff <= wake_ff - 3'h1;
         end
         if (port_role != tcrs_pkg::ROLE_DRP || attached || shutdown
            || adv_source != last_ff || wake_ff != 3'h0) begin
            hold_ff <= 32'h0;
         end else if (clk_en) begin
            hold_ff <= hold_ff + 32'h1;
         end
      end
   end
   sequence s_en_high;
      (enable_n && clk_en)[*4];
   endsequence
   addr_pair_a: assert property (i2c_mode |-> (i2c_addr == 7'h47 || i2c_addr == 7'h67))
      else $error("address outside the strap pair");
   no_i2c_addr_a: assert property (!i2c_mode |-> i2c_addr == 7'h00)
      else $error("address shown without bus mode");
   role_lock_a: assert property ($changed(port_role) |-> !attached)
      else $error("role moved while attached");
   host_flag_a: assert property (clk_en && port_role == tcrs_pkg::ROLE_DRP && attached
      && attach_src_det && !shutdown ##1 attached && !shutdown |-> host_role_flag_n_oe)
      else $error("host flag not pulled");
   od_drive_a: assert property (!change_notify_n_o && !host_role_flag_n_o)
      else $error("open-drain pin driven high");
   shut_release_a: assert property (shutdown |=> !host_role_flag_n_oe)
      else $error("host flag held in shutdown");
   shut_entry_a: assert property (s_en_high |-> ##[0:2] shutdown)
      else $error("shutdown not entered");
   shut_hold_a: assert property (s_en_high ##0 shutdown |=> shutdown)
      else $error("shutdown left early");
   drp_toggle_a: assert property (hold_ff <= DRP_HALF_CYC + 2)
      else $error("advertised role stuck");
endmodule // tcrs_port_ctrl_properties
bind tcrs_port_ctrl tcrs_port_ctrl_properties #(.DRP_HALF_CYC(DRP_HALF_CYC)) u_props (
   .clk, .rst_b, .clk_en, .enable_n, .attach_src_det, .i2c_mode, .i2c_addr, .port_role,
   .attached, .adv_source, .shutdown, .change_notify_n_o, .host_role_flag_n_o,
   .host_role_flag_n_oe);
`default_nettype wire

// ### tcrs_otg_model.sv
/* Behavioural OTG USB controller watching the host role flag.
 Assumes the flag arrives as the resolved wire level with its pull-up. */
`timescale 1ns/1ps
`default_nettype none
module tcrs_otg_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Pins.
   input wire logic flag_n,
   input wire logic vbus_seen,
   output logic host_mode,
   output logic dev_mode,
   output logic vbus_on
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         host_mode <= 1'b0;
         dev_mode <= 1'b0;
         vbus_on <= 1'b0;
      end else begin
         host_mode <= !flag_n;
         vbus_on <= host_mode && !flag_n;
         dev_mode <= flag_n && vbus_seen;
      end
   end
endmodule // tcrs_otg_model
`default_nettype wire

// ### test_typec_port_role_straps.sv
/* Self-checking bench for tcrs_port_ctrl with an OTG controller model.
 Assumes the design files and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_typec_port_role_straps;
   localparam logic [3:0] ST [3] = '{4'h5, 4'hA, 4'h0};
   localparam logic [7:0] AD [3] = '{8'h47, 8'h67, 8'h00};
   localparam logic [7:0] RL [3] = '{8'h00, 8'h01, 8'h02};
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   tcrs_pkg::tcrs_strap_t strap_pins = '0;
   logic enable_n = 1'b0;
   logic src_det = 1'b0;
   logic reg_change = 1'b0;
   logic notify_clear = 1'b0;
   logic role_ovr_wr = 1'b0;
   logic [1:0] role_ovr_val = 2'h0;
   logic notify_link, i2c_mode, attached, adv_source, shutdown, cn_o, cn_oe, hf_o, hf_oe;
   logic host_mode, vbus_on;
   logic [6:0] i2c_addr;
   tcrs_pkg::tcrs_role_t port_role;
   wire logic cn_w = cn_oe ? cn_o : 1'b1;
   wire logic hf_w = hf_oe ? hf_o : 1'b1;
   int err_total = 0;
   int checks_done = 0;
   always #25 clk = ~clk;
   initial #3 forever #7.5 link_clk = ~link_clk;
   tcrs_port_ctrl #(.DRP_HALF_CYC(20)) DUT (.clk, .rst_b, .clk_en, .strap_pins,
      .enable_n, .bus_power_sense(vbus_on), .attach_src_det(src_det), .attach_snk_det(1'b0),
      .link_clk, .reg_change, .notify_clear, .role_ovr_wr, .role_ovr_val,
      .notify_status_link(notify_link), .i2c_mode, .i2c_addr, .port_role, .attached,
      .adv_source, .shutdown, .change_notify_n_i(cn_w), .change_notify_n_o(cn_o),
      .change_notify_n_oe(cn_oe), .host_role_flag_n_i(hf_w), .host_role_flag_n_o(hf_o),
      .host_role_flag_n_oe(hf_oe));
   tcrs_otg_model OTG (.clk, .rst_b, .flag_n(hf_w), .vbus_seen(vbus_on), .host_mode,
      .dev_mode(), .vbus_on);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Pulses one link-side strobe for a single link cycle, then lets it cross.
   task automatic lpulse(input logic [2:0] p, input logic [1:0] v);
      @(negedge link_clk);
      {reg_change, notify_clear, role_ovr_wr} = p;
      role_ovr_val = v;
      @(negedge link_clk);
      {reg_change, notify_clear, role_ovr_wr} = 3'h0;
      cyc(8);
   endtask
   task automatic boot(input logic [3:0] s);
      rst_b = 1'b0;
      strap_pins = s;
      cyc(16);
      rst_b = 1'b1;
      cyc(12);
   endtask
   task automatic end_of_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      logic a;
      for (int i = 0; i < 3; i++) begin
         boot(ST[i]);
         chk(i2c_mode, AD[i] != 8'h00);
         chk(i2c_addr, AD[i]);
         chk(port_role, RL[i]);
      end
      a = adv_source;
      clk_en = 1'b0;
      cyc(25);
      chk(adv_source, a);
      clk_en = 1'b1;
      cyc(22);
      chk(adv_source, !a);
      src_det = 1'b1;
      cyc(4);
      chk(hf_w, 1'b0);
      chk(adv_source, 1'b1);
      chk(attached, 1'b1);
      chk(vbus_on, 1'b1);
      lpulse(3'h1, 2'h1);
      chk(port_role, 8'h02);
      lpulse(3'h2, 2'h1);
      chk(cn_w, 1'b1);
      lpulse(3'h4, 2'h1);
      chk(cn_w, 1'b0);
      chk(notify_link, 1'b1);
      lpulse(3'h2, 2'h1);
      src_det = 1'b0;
      cyc(8);
      chk(port_role, 8'h00);
      chk(attached, 1'b0);
      chk(hf_w, 1'b1);
      chk(cn_w, 1'b0);
      enable_n = 1'b1;
      strap_pins = 4'hA;
      cyc(26);
      chk(shutdown, 1'b1);
      enable_n = 1'b0;
      cyc(14);
      chk(shutdown, 1'b0);
      chk(i2c_addr, 8'h67);
      end_of_test();
   end
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
endmodule // test_typec_port_role_straps
`default_nettype wire
